// file: logic/motion_event_params.svh
// Register offsets, field positions, reset values and timing bases of the motion event bank
`ifndef MOTION_EVENT_PARAMS_SVH
`define MOTION_EVENT_PARAMS_SVH

`define OFS_AXIS_EN 8'h56
`define OFS_X_TAP 8'h57
`define OFS_EVT_EN_Y_TAP 8'h58
`define OFS_ORIENT_Z_TAP 8'h59
`define OFS_TAP_WINDOWS 8'h5a
`define OFS_WAKE_THS 8'h5b
`define OFS_DURATIONS 8'h5c
`define OFS_FALL_LOW 8'h5d
`define OFS_IRQ_STATUS 8'h60
`define OFS_IRQ_MASK 8'h61
`define BANK_FIRST 8'h56
`define BANK_LAST 8'h5d

`define IDX_AXIS_EN 3'd0
`define IDX_X_TAP 3'd1
`define IDX_EVT_EN 3'd2
`define IDX_ORIENT 3'd3
`define IDX_WINDOWS 3'd4
`define IDX_WAKE 3'd5
`define IDX_DUR 3'd6
`define IDX_FALL 3'd7

`define BANK_RESET 8'h00
`define IRQ_RESET 6'h00

`define X_EN_BIT 3
`define Y_EN_BIT 2
`define Z_EN_BIT 1
`define TAP_LVL_MSB 4
`define TAP_LVL_LSB 0
`define MASTER_EN_BIT 7
`define POLICY_MSB 6
`define POLICY_LSB 5
`define PLANAR_BIT 7
`define ANGLE_MSB 6
`define ANGLE_LSB 5
`define GAP_MSB 7
`define GAP_LSB 4
`define QUIET_MSB 3
`define QUIET_LSB 2
`define SHOCK_MSB 1
`define SHOCK_LSB 0
`define TAP_MODE_BIT 7
`define WAKE_SRC_BIT 6
`define WAKE_LVL_MSB 5
`define WAKE_LVL_LSB 0
`define FALL_MSB_BIT 7
`define WAKE_PERSIST_COUNT_MSB 6
`define WAKE_PERSIST_COUNT_LSB 5
`define WAKE_WEIGHT_BIT 4
`define SLEEP_MSB 3
`define SLEEP_LSB 0
`define FALL_LOW_MSB 7
`define FALL_LOW_LSB 3

`define EV_SINGLE 0
`define EV_DOUBLE 1
`define EV_WAKE 2
`define EV_FALL 3
`define EV_SLEEP 4
`define EV_ORIENT 5

`define GAP_BASE 13'd16
`define GAP_STEP 13'd32
`define QUIET_BASE 13'd2
`define QUIET_STEP 13'd4
`define SHOCK_BASE 13'd4
`define SHOCK_STEP 13'd8
`define SLEEP_BASE 13'd16
`define SLEEP_STEP 13'd512

`define ANGLE_00 7'd80
`define ANGLE_01 7'd70
`define ANGLE_10 7'd60
`define ANGLE_11 7'd50

`define POLICY_NONE 2'b00
`define POLICY_GYRO_SLEEP 2'b10
`define POLICY_GYRO_OFF 2'b11

`endif

// file: logic/motion_event_pkg.sv
// Types shared by the motion event configuration bank
package motion_event_pkg;

  typedef enum logic [3:0] {
    TAP_IDLE = 4'b0001,
    TAP_OVER = 4'b0010,
    TAP_QUIET = 4'b0100,
    TAP_GAP = 4'b1000
  } tap_state_t;

  // Magnitudes, 1 LSB = accel_full_scale / 256
  typedef struct packed {
    logic [7:0] x_mag;
    logic [7:0] y_mag;
    logic [7:0] z_mag;
    logic [7:0] wake_highpass;
    logic [7:0] wake_lowpass_offset;
    logic fall_below;
    logic orient_change;
  } accel_sample_t;

  typedef struct packed {
    logic sleeping;
    logic accel_low_power;
    logic gyro_sleep;
    logic gyro_power_down;
  } power_ctl_t;

  typedef struct packed {
    logic planar_orientation_only;
    logic [6:0] angle_deg;
  } orient_cfg_t;

  typedef struct packed {
    logic [7:0][7:0] bank;
    logic [5:0] status;
    logic [5:0] mask;
    tap_state_t tap;
    logic [12:0] tap_cnt;
    logic second_tap;
    logic [2:0] wake_cnt;
    logic [6:0] fall_cnt;
    logic [12:0] still_cnt;
    logic [7:0] rdata;
    logic irq;
    logic [5:0] events;
    power_ctl_t power;
    orient_cfg_t orient;
  } bank_state_t;

endpackage

// file: logic/motion_event_config_bank.sv
// Motion event configuration bank with tap, wake, sleep and free-fall detectors
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`include "motion_event_params.svh"

module motion_event_config_bank (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic sample_valid,
  input wire motion_event_pkg::accel_sample_t sample,
  output logic [7:0] rdata,
  output logic irq,
  output logic [5:0] events,
  output motion_event_pkg::power_ctl_t power,
  output motion_event_pkg::orient_cfg_t orient
);
  import motion_event_pkg::*;

  bank_state_t st;
  bank_state_t next_st;

  // Window length: base when field is zero, else field times step
  function automatic logic [12:0] window_len(input logic [3:0] field, input logic [12:0] base,
                                             input logic [12:0] step);
    logic [12:0] prod;
    prod = 13'({9'd0, field} * step);
    return (field == 4'd0) ? base : prod;
  endfunction

  function automatic logic [6:0] angle_of(input logic [1:0] lvl);
    logic [6:0] deg;
    case (lvl)
      2'b00: deg = `ANGLE_00;
      2'b01: deg = `ANGLE_01;
      2'b10: deg = `ANGLE_10;
      default: deg = `ANGLE_11;
    endcase
    return deg;
  endfunction

  // Five-bit tap level scaled onto the 1/256 magnitude grid
  function automatic logic tap_over(input logic en, input logic [7:0] mag, input logic [4:0] lvl);
    return en && (mag >= {lvl, 3'b000});
  endfunction

  logic [7:0] r_axis, r_xtap, r_evt, r_ori, r_win, r_wake, r_dur, r_fall;
  logic over, above;
  logic [7:0] wake_src, wake_thr;
  logic [12:0] gap_len, quiet_len, shock_len, sleep_len;
  logic [2:0] wake_need;
  logic [6:0] fall_need;
  logic [5:0] raw_ev;
  logic in_bank;
  logic [2:0] bank_idx;

  always_comb begin
    r_axis = st.bank[`IDX_AXIS_EN];
    r_xtap = st.bank[`IDX_X_TAP];
    r_evt = st.bank[`IDX_EVT_EN];
    r_ori = st.bank[`IDX_ORIENT];
    r_win = st.bank[`IDX_WINDOWS];
    r_wake = st.bank[`IDX_WAKE];
    r_dur = st.bank[`IDX_DUR];
    r_fall = st.bank[`IDX_FALL];
    in_bank = (addr >= `BANK_FIRST) && (addr <= `BANK_LAST);
    bank_idx = 3'(addr - `BANK_FIRST);
    over = tap_over(r_axis[`X_EN_BIT], sample.x_mag, r_xtap[`TAP_LVL_MSB:`TAP_LVL_LSB]) ||
           tap_over(r_axis[`Y_EN_BIT], sample.y_mag, r_evt[`TAP_LVL_MSB:`TAP_LVL_LSB]) ||
           tap_over(r_axis[`Z_EN_BIT], sample.z_mag, r_ori[`TAP_LVL_MSB:`TAP_LVL_LSB]);
    wake_src = r_wake[`WAKE_SRC_BIT] ? sample.wake_lowpass_offset : sample.wake_highpass;
    wake_thr = r_dur[`WAKE_WEIGHT_BIT] ? {2'b00, r_wake[`WAKE_LVL_MSB:`WAKE_LVL_LSB]}
                                       : {r_wake[`WAKE_LVL_MSB:`WAKE_LVL_LSB], 2'b00};
    above = wake_src >= wake_thr;
    gap_len = window_len(r_win[`GAP_MSB:`GAP_LSB], `GAP_BASE, `GAP_STEP);
    quiet_len = window_len({2'b00, r_win[`QUIET_MSB:`QUIET_LSB]}, `QUIET_BASE, `QUIET_STEP);
    shock_len = window_len({2'b00, r_win[`SHOCK_MSB:`SHOCK_LSB]}, `SHOCK_BASE, `SHOCK_STEP);
    sleep_len = window_len(r_dur[`SLEEP_MSB:`SLEEP_LSB], `SLEEP_BASE, `SLEEP_STEP);
    wake_need = {1'b0, r_dur[`WAKE_PERSIST_COUNT_MSB:`WAKE_PERSIST_COUNT_LSB]};
    fall_need = {1'b0, r_dur[`FALL_MSB_BIT], r_fall[`FALL_LOW_MSB:`FALL_LOW_LSB]};
  end

  always_comb begin
    next_st = st;
    raw_ev = 6'h00;
    next_st.rdata = 8'h00;
    // Register port; reads of the status word clear it below
    if (wr) begin
      if (in_bank) begin
        next_st.bank[bank_idx] = wdata;
      end else if (addr == `OFS_IRQ_MASK) begin
        next_st.mask = wdata[5:0];
      end
    end
    if (rd) begin
      if (in_bank) begin
        next_st.rdata = st.bank[bank_idx];
      end else if (addr == `OFS_IRQ_STATUS) begin
        next_st.rdata = {2'b00, st.status};
      end else if (addr == `OFS_IRQ_MASK) begin
        next_st.rdata = {2'b00, st.mask};
      end
    end
    // Detectors only move on a sample, so a written value takes effect on the next one
    if (sample_valid) begin
      case (st.tap)
        TAP_IDLE: begin
          if (over) begin
            next_st.tap = TAP_OVER;
            next_st.tap_cnt = 13'd1;
          end
        end
        TAP_OVER: begin
          if (over) begin
            if (st.tap_cnt <= shock_len) begin
              next_st.tap_cnt = st.tap_cnt + 13'd1;
            end
          end else if (st.tap_cnt <= shock_len) begin
            if (st.second_tap && r_wake[`TAP_MODE_BIT]) begin
              // Pending flag stays up through quiet so a third tap cannot pair again
              raw_ev[`EV_DOUBLE] = 1'b1;
            end else begin
              raw_ev[`EV_SINGLE] = 1'b1;
            end
            next_st.tap = TAP_QUIET;
            next_st.tap_cnt = 13'd0;
          end else begin
            // Too long for a tap: drop any pending double
            next_st.tap = TAP_IDLE;
            next_st.second_tap = 1'b0;
          end
        end
        TAP_QUIET: begin
          if (over) begin
            next_st.tap_cnt = 13'd0;
          end else if (st.tap_cnt + 13'd1 >= quiet_len) begin
            next_st.tap_cnt = 13'd0;
            if (r_wake[`TAP_MODE_BIT] && !st.second_tap) begin
              next_st.tap = TAP_GAP;
              next_st.second_tap = 1'b1;
            end else begin
              next_st.tap = TAP_IDLE;
              next_st.second_tap = 1'b0;
            end
          end else begin
            next_st.tap_cnt = st.tap_cnt + 13'd1;
          end
        end
        TAP_GAP: begin
          if (over) begin
            next_st.tap = TAP_OVER;
            next_st.tap_cnt = 13'd1;
          end else if (st.tap_cnt + 13'd1 >= gap_len) begin
            next_st.tap = TAP_IDLE;
            next_st.second_tap = 1'b0;
            next_st.tap_cnt = 13'd0;
          end else begin
            next_st.tap_cnt = st.tap_cnt + 13'd1;
          end
        end
        default: begin
          next_st.tap = TAP_IDLE;
          next_st.tap_cnt = 13'd0;
          next_st.second_tap = 1'b0;
        end
      endcase
      // Wake and fall counters saturate one past their target so each episode fires once
      if (above) begin
        if (st.wake_cnt <= wake_need) begin
          next_st.wake_cnt = st.wake_cnt + 3'd1;
        end
        raw_ev[`EV_WAKE] = (st.wake_cnt == wake_need);
        next_st.still_cnt = 13'd0;
        if (st.power.sleeping) begin
          next_st.power.sleeping = 1'b0;
          raw_ev[`EV_SLEEP] = 1'b1;
        end
      end else begin
        next_st.wake_cnt = 3'd0;
        if (!st.power.sleeping) begin
          if (st.still_cnt + 13'd1 >= sleep_len) begin
            next_st.power.sleeping = 1'b1;
            next_st.still_cnt = 13'd0;
            raw_ev[`EV_SLEEP] = 1'b1;
          end else begin
            next_st.still_cnt = st.still_cnt + 13'd1;
          end
        end
      end
      if (sample.fall_below) begin
        if (st.fall_cnt <= fall_need) begin
          next_st.fall_cnt = st.fall_cnt + 7'd1;
        end
        raw_ev[`EV_FALL] = (st.fall_cnt == fall_need);
      end else begin
        next_st.fall_cnt = 7'd0;
      end
      raw_ev[`EV_ORIENT] = sample.orient_change;
      next_st.orient.planar_orientation_only = r_ori[`PLANAR_BIT];
      next_st.orient.angle_deg = angle_of(r_ori[`ANGLE_MSB:`ANGLE_LSB]);
    end
    // Power policy follows the sleep state
    next_st.power.accel_low_power = next_st.power.sleeping &&
                                    (r_evt[`POLICY_MSB:`POLICY_LSB] != `POLICY_NONE);
    next_st.power.gyro_sleep = next_st.power.sleeping &&
                               (r_evt[`POLICY_MSB:`POLICY_LSB] == `POLICY_GYRO_SLEEP);
    next_st.power.gyro_power_down = next_st.power.sleeping &&
                                    (r_evt[`POLICY_MSB:`POLICY_LSB] == `POLICY_GYRO_OFF);
    next_st.events = raw_ev & {6{r_evt[`MASTER_EN_BIT]}};
    // Set wins over the read clear so no event is lost
    if (rd && addr == `OFS_IRQ_STATUS) begin
      next_st.status = next_st.events;
    end else begin
      next_st.status = st.status | next_st.events;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{bank: {8{`BANK_RESET}}, status: `IRQ_RESET, mask: `IRQ_RESET, tap: TAP_IDLE,
              orient: '{planar_orientation_only: 1'b0, angle_deg: `ANGLE_00}, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq = st.irq;
  assign events = st.events;
  assign power = st.power;
  assign orient = st.orient;

  master_gate_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !r_evt[`MASTER_EN_BIT] |=> st.events == 6'h00)
    else $error("event raised while master enable clear");

  policy_power_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.power.gyro_sleep || st.power.gyro_power_down |-> st.power.accel_low_power && st.power.sleeping)
    else $error("gyro power change without accel low power");

  orient_angle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_valid |=> st.orient.angle_deg == angle_of($past(r_ori[`ANGLE_MSB:`ANGLE_LSB])))
    else $error("orientation angle not taken from level");

  planar_copy_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !sample_valid |=> $stable(st.orient.planar_orientation_only))
    else $error("planar flag changed between samples");

  gap_bound_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.tap == TAP_GAP |-> st.tap_cnt < gap_len)
    else $error("double tap gap overrun");

  quiet_bound_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.tap == TAP_QUIET |-> st.tap_cnt < quiet_len)
    else $error("quiet window overrun");

  shock_limit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_valid && st.tap == TAP_OVER && !over && st.tap_cnt > shock_len
    |=> st.events[`EV_DOUBLE:`EV_SINGLE] == 2'b00)
    else $error("long pulse taken as tap");

  single_mode_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !$past(r_wake[`TAP_MODE_BIT]) |-> !st.events[`EV_DOUBLE])
    else $error("double tap in single mode");

  wake_persist_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.events[`EV_WAKE] |-> $past(above) && $past(sample_valid))
    else $error("wake without persisting condition");

  sleep_bound_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st.power.sleeping |-> st.still_cnt < sleep_len)
    else $error("sleep count overrun");

  axis_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    r_axis[`X_EN_BIT:`Z_EN_BIT] == 3'b000 && st.tap == TAP_IDLE |=> st.tap == TAP_IDLE)
    else $error("tap started with all axes disabled");

  irq_level_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(wr && addr == `OFS_IRQ_MASK) |-> irq == |(st.status & $past(wdata[5:0])))
    else $error("interrupt level wrong after mask write");

  status_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(rd && addr == `OFS_IRQ_STATUS) |-> st.status == st.events)
    else $error("status not cleared by read");

  status_sticky_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !$past(rd && addr == `OFS_IRQ_STATUS) |-> (st.status & $past(st.status)) == $past(st.status))
    else $error("status bit lost without read");

  read_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");

  bank_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(wr && in_bank) |-> st.bank[$past(bank_idx)] == $past(wdata))
    else $error("register write lost");

  bank_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(rd && in_bank) |-> rdata == $past(st.bank[bank_idx]))
    else $error("register read data wrong");

  sample_only_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !$past(sample_valid) |-> st.events == 6'h00)
    else $error("event raised without a sample");

  orient_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !sample_valid |=> $stable(st.orient.angle_deg))
    else $error("angle changed between samples");

  orient_event_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $past(sample_valid && sample.orient_change && r_evt[`MASTER_EN_BIT]) |-> st.events[`EV_ORIENT])
    else $error("orientation change not reported");

  policy_none_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    r_evt[`POLICY_MSB:`POLICY_LSB] == `POLICY_NONE |=> !st.power.accel_low_power)
    else $error("accel rate changed under no-change policy");

  gyro_policy_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !r_evt[`POLICY_MSB] |=> !st.power.gyro_sleep && !st.power.gyro_power_down)
    else $error("gyro power changed under accel-only policy");

  tap_start_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_valid && st.tap == TAP_IDLE && !over |=> st.tap == TAP_IDLE)
    else $error("tap started below level");

  single_release_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.events[`EV_SINGLE] |-> $past(st.tap) == TAP_OVER && !$past(over) &&
                              $past(st.tap_cnt) <= $past(shock_len))
    else $error("single tap without short pulse");

  double_pending_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.events[`EV_DOUBLE] |-> $past(st.second_tap))
    else $error("double tap without first tap");

  wake_restart_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_valid && !above |=> st.wake_cnt == 3'd0)
    else $error("wake count kept over a quiet sample");

  fall_event_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    st.events[`EV_FALL] |-> $past(sample_valid) && $past(sample.fall_below))
    else $error("free fall without fall condition");

  fall_restart_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sample_valid && !sample.fall_below |=> st.fall_cnt == 7'd0)
    else $error("fall count kept over a normal sample");

  sleep_enter_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(st.power.sleeping) |-> $past(sample_valid) && !$past(above))
    else $error("sleep entered on an active sample");

  sleep_exit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(st.power.sleeping) |-> $past(sample_valid) && $past(above))
    else $error("sleep left without activity");

  sleep_event_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $changed(st.power.sleeping) && $past(r_evt[`MASTER_EN_BIT]) |-> st.events[`EV_SLEEP])
    else $error("sleep change not reported");

endmodule

// file: dv/motion_event_config_bank_bench.sv
// Self-checking random bench for the motion event configuration bank
`timescale 1ns/1ns
`include "motion_event_params.svh"

module motion_event_config_bank_bench;
  import motion_event_pkg::*;
  logic core_clk;
  logic arst_n;
  logic wr;
  logic rd;
  logic sample_valid;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq;
  logic [5:0] events;
  accel_sample_t sample;
  power_ctl_t power;
  orient_cfg_t orient;
  int fails;
  int num_checks;
  integer seed;
  logic [7:0] v;
  logic [7:0] ev;

  motion_event_config_bank u_motion_event_config_bank (.core_clk(core_clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .sample_valid(sample_valid), .sample(sample), .rdata(rdata),
    .irq(irq), .events(events), .power(power), .orient(orient));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic int win(input int f, input int base, input int step);
    return f == 0 ? base : f * step;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Events land at the sample edge, so they are caught just after it
  task automatic smp(input logic [7:0] x, y, z, hp, lp, input logic fb);
    @(posedge core_clk);
    sample <= '{x, y, z, hp, lp, fb, 1'($random(seed))};
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    #1 ev = {2'b00, events};
  endtask

  task automatic idle(input int n);
    repeat (n) smp(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
  endtask

  task automatic wk(input logic w, input logic [7:0] m, input int n);
    repeat (n) smp(8'h00, 8'h00, 8'h00, w ? 8'h00 : m, w ? m : 8'h00, 1'b0);
  endtask

  // Over-threshold on one axis for n samples, then released
  task automatic tap(input int i, input logic [7:0] mag, input int n);
    logic [7:0] m [3];
    m = '{8'h00, 8'h00, 8'h00};
    m[i] = mag;
    repeat (n) smp(m[0], m[1], m[2], 8'h00, 8'h00, 1'b0);
    idle(1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run is about 10 us; generous margin
  initial begin
    #200000;
    fails++;
    summarize();
  end

  initial begin
    logic [4:0] lv [3];
    logic [5:0] l;
    logic [7:0] r;
    seed = 14341;
    fails = 0;
    num_checks = 0;
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    sample_valid = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    sample = '0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    chk(orient, 8'h50, "orient reset");
    chk({4'h0, power}, 8'h00, "power reset");
    // Covers two unmapped holes, status and mask as well
    for (int a = 'h56; a <= 'h61; a++) begin
      rreg(a[7:0], v);
      chk(v, 8'h00, "reset value");
    end
    for (int a = 'h56; a <= 'h5d; a++) begin
      r = 8'($random(seed));
      wreg(a[7:0], r);
      rreg(a[7:0], v);
      chk(v, r, "readback");
    end
    wreg(8'h60, 8'hff);
    rreg(8'h60, v);
    chk(v, 8'h00, "status write ignored");
    for (int a = 'h56; a <= 'h5d; a++) wreg(a[7:0], 8'h00);
    for (int c = 0; c < 4; c++) begin
      wreg(8'h59, {c[0], c[1:0], 5'h00});
      idle(1);
      chk(orient, {c[0], 7'(80 - 10 * c)}, "orient");
    end
    wreg(8'h5b, 8'h3f);
    for (int i = 0; i < 3; i++) lv[i] = 5'($random(seed)) | 5'h01;
    wreg(8'h57, {3'b000, lv[0]});
    wreg(8'h58, {3'b100, lv[1]});
    wreg(8'h59, {3'b000, lv[2]});
    for (int i = 0; i < 3; i++) begin
      wreg(8'h56, 8'h08 >> i);
      tap(i, {lv[i], 3'b000} - 8'd1, 1);
      chk(ev & 8'h03, 8'h00, "under level");
      tap(i, {lv[i], 3'b000}, 1);
      chk(ev & 8'h03, 8'h01, "tap");
      idle(3);
      tap((i + 1) % 3, 8'hf8, 1);
      chk(ev & 8'h03, 8'h00, "axis off");
      idle(3);
    end
    wreg(8'h56, 8'h04);
    wreg(8'h58, {3'b000, lv[1]});
    tap(1, 8'hf8, 1);
    chk(ev, 8'h00, "master off");
    idle(3);
    wreg(8'h58, {3'b100, lv[1]});
    for (int f = 0; f < 2; f++) begin
      wreg(8'h5a, 8'(f));
      tap(1, 8'hf8, win(f, 4, 8));
      chk(ev & 8'h01, 8'h01, "shock max");
      idle(3);
      tap(1, 8'hf8, win(f, 4, 8) + 1);
      chk(ev & 8'h01, 8'h00, "shock over");
      idle(3);
    end
    for (int md = 0; md < 2; md++) begin
      wreg(8'h5b, {md[0], 7'h3f});
      wreg(8'h5a, 8'h14);
      tap(1, 8'hf8, 1);
      idle(win(1, 2, 4));
      tap(1, 8'hf8, 1);
      chk(ev & 8'h03, {6'h00, md[0], !md[0]}, "tap mode");
      idle(40);
    end
    // Twenty gap samples: beyond a 16 limit, inside a 32 limit
    for (int g = 0; g < 2; g++) begin
      wreg(8'h5a, {3'b000, g[0], 4'h4});
      tap(1, 8'hf8, 1);
      idle(win(1, 2, 4) + 20);
      tap(1, 8'hf8, 1);
      chk(ev & 8'h02, {6'h00, g[0], 1'b0}, "gap");
      idle(40);
    end
    for (int w = 0; w < 2; w++) begin
      l = 6'($random(seed)) | 6'h01;
      r = w ? {2'b00, l} : {l, 2'b00};
      wreg(8'h5b, {1'b0, w[0], l});
      wreg(8'h5c, {3'b010, w[0], 4'h0});
      wk(!w[0], 8'hff, 3);
      chk(ev & 8'h04, 8'h00, "wake source");
      idle(1);
      wk(w[0], r - 8'd1, 3);
      chk(ev & 8'h04, 8'h00, "wake below");
      idle(1);
      wk(w[0], r, 2);
      chk(ev & 8'h04, 8'h00, "wake early");
      wk(w[0], r, 1);
      chk(ev & 8'h04, 8'h04, "wake");
    end
    wreg(8'h5b, 8'h3f);
    wreg(8'h5c, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wreg(8'h58, {1'b1, p[1:0], lv[1]});
      wk(1'b0, 8'hff, 1);
      chk({4'h0, power}, 8'h00, "awake power");
      wk(1'b0, 8'h00, 15);
      chk(ev & 8'h10, 8'h00, "sleep early");
      wk(1'b0, 8'h00, 1);
      chk(ev & 8'h10, 8'h10, "sleep");
      chk({4'h0, power}, {4'h0, 1'b1, 1'(p != 0), 1'(p == 2), 1'(p == 3)}, "policy");
    end
    wreg(8'h5c, 8'h01);
    wk(1'b0, 8'hff, 1);
    wk(1'b0, 8'h00, 511);
    chk(ev & 8'h10, 8'h00, "long sleep early");
    wk(1'b0, 8'h00, 1);
    chk(ev & 8'h10, 8'h10, "long sleep");
    wreg(8'h5c, 8'h80);
    wreg(8'h5d, 8'h08);
    wreg(8'h61, 8'h08);
    rreg(8'h60, v);
    repeat (33) smp(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    chk(ev & 8'h08, 8'h00, "fall early");
    chk({7'h00, irq}, 8'h00, "irq idle");
    smp(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    chk(ev & 8'h08, 8'h08, "fall");
    chk({7'h00, irq}, 8'h01, "irq raised");
    wreg(8'h61, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({7'h00, irq}, 8'h00, "irq masked");
    wreg(8'h61, 8'h08);
    repeat (2) @(posedge core_clk);
    chk({7'h00, irq}, 8'h01, "irq unmasked");
    rreg(8'h60, v);
    chk(v & 8'h08, 8'h08, "status");
    repeat (2) @(posedge core_clk);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    rreg(8'h60, v);
    chk(v, 8'h00, "status cleared");
    summarize();
  end
endmodule
